// ---- timer_pkg.sv ----
// constants, field layout and carrier types of the sixteen-bit timer core
// assumes a byte-wide register port on the same clock as the timer
package timer_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [7:0] OFS_COUNT_LOW    = 8'hE2;
    localparam logic [7:0] OFS_COUNT_HIGH   = 8'hE3;
    localparam logic [7:0] OFS_CONTROL      = 8'hE4;
    localparam logic [7:0] OFS_CHAN0_CTL    = 8'hE5;

    // control/status field positions
    localparam int CTL_CHAN2_BIT = 7;
    localparam int CTL_CHAN1_BIT = 6;
    localparam int CTL_CHAN0_BIT = 5;
    localparam int CTL_WRAP_BIT  = 4;
    localparam int CTL_DIV_LSB   = 2;
    localparam int CTL_MODE_LSB  = 0;

    // channel 0 control field positions
    localparam int CH0_SEL_BIT   = 7;
    localparam int CH0_MASK_BIT  = 6;
    localparam int CH0_ACT_LSB   = 3;
    localparam int CH0_FUNC_BIT  = 2;
    localparam int CH0_EDGE_LSB  = 0;

    // values after reset, and the free-running top count
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [7:0]  CHAN0_RESET   = 8'h40;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] COUNT_TOP     = 16'hFFFF;

    // prescaler: tick count masks for divide by 1, 8, 32, 128
    localparam int          PRE_W        = 7;
    localparam logic [6:0]  PRE_MASK_1   = 7'h00;
    localparam logic [6:0]  PRE_MASK_8   = 7'h07;
    localparam logic [6:0]  PRE_MASK_32  = 7'h1F;
    localparam logic [6:0]  PRE_MASK_128 = 7'h7F;

    // timer modes
    localparam logic [1:0] MODE_HOLD  = 2'h0;
    localparam logic [1:0] MODE_FREE  = 2'h1;
    localparam logic [1:0] MODE_MOD   = 2'h2;
    localparam logic [1:0] MODE_UPDN  = 2'h3;

    // compare actions
    localparam logic [2:0] ACT_SET     = 3'h0;
    localparam logic [2:0] ACT_CLEAR   = 3'h1;
    localparam logic [2:0] ACT_TOGGLE  = 3'h2;
    localparam logic [2:0] ACT_SET_UP  = 3'h3;
    localparam logic [2:0] ACT_CLR_UP  = 3'h4;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic [7:0]  holdHigh;
        logic [7:0]  ctl;
        logic [7:0]  ch0Ctl;
        logic [6:0]  pre;
        logic        down;
        logic        outLvl;
        logic [1:0]  pinSync;
        logic        pinPrev;
        logic [15:0] capVal;
        logic        capStb;
        logic        ch0Evt;
        logic [7:0]  rdData;
    } state_t;

endpackage

// ---- timer_core.sv ----
// sixteen-bit timer: counter, prescaler, mode control, pending flags, channel 0 control
// assumes tick, radio events and channel 1/2 events come from logic on clk;
// the capture pin is asynchronous and is synchronised here
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - low byte read latches high byte
// - any low byte write clears counter
// - channel pending flags in bits 7:5
// - wrap flag at terminal count or zero turn
// - prescaler divides tick by 1/8/32/128
// - prescaler counter never reset by writes
// - mode 00 holds the counter
// - mode 01 counts 0 to FFFF, wraps
// - mode 10 counts 0 to match, restarts
// - mode 11 counts up then down
// - select bit picks pin or radio events
// - action field steers output on match
// - actions set, clear, toggle on match
// - action 011 set up, clear zero/down
// - action 100 clear up, set zero/down
// - bit 2 picks capture or compare
// - edge field picks capture edges
// - flags always set; request needs mask, enable
// - up/down compare: zero sets both flags
module timer_core (
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic                clkEn,
    input  wire timer_pkg::bus_req_t busReq,
    output logic [7:0]               rdData,
    input  wire logic                tick,
    input  wire logic                capturePin,
    input  wire logic [7:0]          radioEvent,
    input  wire logic [7:0]          radioEventMask,
    input  wire logic [15:0]         chan0MatchValue,
    input  wire logic                chan1Event,
    input  wire logic                chan2Event,
    input  wire logic                chan1IrqMask,
    input  wire logic                chan2IrqMask,
    input  wire logic                wrapIrqMask,
    input  wire logic                timerIrqEnable,
    output logic [15:0]              tallyValue,
    output logic                     countingDown,
    output logic                     chan0Out,
    output logic [15:0]              captureValue,
    output logic                     captureStrobe,
    output logic                     chan0Trigger,
    output logic                     irqReq
);

    timer_pkg::state_t s_r;
    timer_pkg::state_t s_nxt;

    logic [1:0]  mode;
    logic [1:0]  div;
    logic [2:0]  act;
    logic [1:0]  edgeSel;
    logic        cmpMode;
    logic [6:0]  preMask;
    logic        advance;
    logic [15:0] cntStep;
    logic        dirStep;
    logic        wrapEvt;
    logic        matchHit;
    logic        zeroHit;
    logic        rise;
    logic        fall;
    logic        capTrig;
    logic        ch0Set;
    logic        wrLow;
    logic        rdLow;
    logic        wrCtl;

    assign mode    = s_r.ctl[timer_pkg::CTL_MODE_LSB +: 2];
    assign div     = s_r.ctl[timer_pkg::CTL_DIV_LSB +: 2];
    assign act     = s_r.ch0Ctl[timer_pkg::CH0_ACT_LSB +: 3];
    assign edgeSel = s_r.ch0Ctl[timer_pkg::CH0_EDGE_LSB +: 2];
    assign cmpMode = s_r.ch0Ctl[timer_pkg::CH0_FUNC_BIT];
    assign wrLow   = busReq.wr && (busReq.addr == timer_pkg::OFS_COUNT_LOW);
    assign rdLow   = busReq.rd && (busReq.addr == timer_pkg::OFS_COUNT_LOW);
    assign wrCtl   = busReq.wr && (busReq.addr == timer_pkg::OFS_CONTROL);

    always_comb begin
        s_nxt = s_r;

        case (div)
            2'h0:    preMask = timer_pkg::PRE_MASK_1;
            2'h1:    preMask = timer_pkg::PRE_MASK_8;
            2'h2:    preMask = timer_pkg::PRE_MASK_32;
            default: preMask = timer_pkg::PRE_MASK_128;
        endcase
        // free-running on ticks; a new divider only waits for its mask to line up
        s_nxt.pre = tick ? s_r.pre + 7'h01 : s_r.pre;
        advance   = tick && ((s_r.pre & preMask) == preMask) &&
                    (mode != timer_pkg::MODE_HOLD);

        cntStep = s_r.cnt;
        dirStep = s_r.down;
        wrapEvt = 1'b0;
        case (mode)
            timer_pkg::MODE_FREE: begin
                wrapEvt = (s_r.cnt == timer_pkg::COUNT_TOP);
                cntStep = wrapEvt ? timer_pkg::COUNT_RESET : s_r.cnt + 16'h0001;
                dirStep = 1'b0;
            end
            timer_pkg::MODE_MOD: begin
                // >= so a match moved below the count still restarts at once
                wrapEvt = (s_r.cnt >= chan0MatchValue);
                cntStep = wrapEvt ? timer_pkg::COUNT_RESET : s_r.cnt + 16'h0001;
                dirStep = 1'b0;
            end
            timer_pkg::MODE_UPDN: begin
                if (!s_r.down) begin
                    if (s_r.cnt >= chan0MatchValue) begin
                        if (s_r.cnt == timer_pkg::COUNT_RESET) begin
                            wrapEvt = 1'b1;
                        end else begin
                            dirStep = 1'b1;
                            cntStep = s_r.cnt - 16'h0001;
                        end
                    end else begin
                        cntStep = s_r.cnt + 16'h0001;
                    end
                end else if (s_r.cnt == timer_pkg::COUNT_RESET) begin
                    wrapEvt = 1'b1;
                    dirStep = 1'b0;
                    cntStep = (chan0MatchValue == timer_pkg::COUNT_RESET) ?
                              timer_pkg::COUNT_RESET : 16'h0001;
                end else begin
                    cntStep = s_r.cnt - 16'h0001;
                end
            end
            default: begin
                cntStep = s_r.cnt;
            end
        endcase
        wrapEvt  = wrapEvt && advance;
        matchHit = advance && (cntStep == chan0MatchValue);
        zeroHit  = advance && (cntStep == timer_pkg::COUNT_RESET);

        if (advance) begin
            s_nxt.cnt  = cntStep;
            s_nxt.down = dirStep;
        end
        if (wrLow) begin
            s_nxt.cnt  = timer_pkg::COUNT_RESET;
            s_nxt.down = 1'b0;
        end

        // compare output; reserved codes leave it alone
        if (cmpMode) begin
            case (act)
                timer_pkg::ACT_SET: begin
                    if (matchHit) s_nxt.outLvl = 1'b1;
                end
                timer_pkg::ACT_CLEAR: begin
                    if (matchHit) s_nxt.outLvl = 1'b0;
                end
                timer_pkg::ACT_TOGGLE: begin
                    if (matchHit) s_nxt.outLvl = !s_r.outLvl;
                end
                timer_pkg::ACT_SET_UP: begin
                    if (matchHit && !s_r.down) s_nxt.outLvl = 1'b1;
                    else if (mode == timer_pkg::MODE_UPDN ? (matchHit && s_r.down) : zeroHit)
                        s_nxt.outLvl = 1'b0;
                end
                timer_pkg::ACT_CLR_UP: begin
                    if (matchHit && !s_r.down) s_nxt.outLvl = 1'b0;
                    else if (mode == timer_pkg::MODE_UPDN ? (matchHit && s_r.down) : zeroHit)
                        s_nxt.outLvl = 1'b1;
                end
                default: s_nxt.outLvl = s_r.outLvl;
            endcase
        end

        // capture path; first sync stage feeds only the second
        s_nxt.pinSync = {s_r.pinSync[0], capturePin};
        s_nxt.pinPrev = s_r.pinSync[1];
        rise    = s_r.pinSync[1] && !s_r.pinPrev;
        fall    = !s_r.pinSync[1] && s_r.pinPrev;
        capTrig = !cmpMode && (s_r.ch0Ctl[timer_pkg::CH0_SEL_BIT] ?
                  ((|(radioEvent & radioEventMask)) && (edgeSel != 2'h0)) :
                  ((edgeSel[0] && rise) || (edgeSel[1] && fall)));
        s_nxt.capStb = capTrig;
        if (capTrig) s_nxt.capVal = s_r.cnt;

        // channel 0 event: compare match, zero turn in up/down, or capture
        ch0Set = cmpMode ? ((mode == timer_pkg::MODE_UPDN) ? wrapEvt : matchHit)
                         : capTrig;
        s_nxt.ch0Evt = ch0Set;

        // register writes
        if (wrCtl) s_nxt.ctl = busReq.wdata;
        if (busReq.wr && busReq.addr == timer_pkg::OFS_CHAN0_CTL) s_nxt.ch0Ctl = busReq.wdata;
        // hardware sets after the write so a same-cycle event wins
        if (ch0Set)     s_nxt.ctl[timer_pkg::CTL_CHAN0_BIT] = 1'b1;
        if (chan1Event) s_nxt.ctl[timer_pkg::CTL_CHAN1_BIT] = 1'b1;
        if (chan2Event) s_nxt.ctl[timer_pkg::CTL_CHAN2_BIT] = 1'b1;
        if (wrapEvt)    s_nxt.ctl[timer_pkg::CTL_WRAP_BIT]  = 1'b1;

        // reads: data in the following cycle only
        s_nxt.rdData = 8'h00;
        if (busReq.rd) begin
            case (busReq.addr)
                timer_pkg::OFS_COUNT_LOW:  s_nxt.rdData = s_r.cnt[7:0];
                timer_pkg::OFS_COUNT_HIGH: s_nxt.rdData = s_r.holdHigh;
                timer_pkg::OFS_CONTROL:    s_nxt.rdData = s_r.ctl;
                timer_pkg::OFS_CHAN0_CTL:  s_nxt.rdData = s_r.ch0Ctl;
                default:                   s_nxt.rdData = 8'h00;
            endcase
        end
        if (rdLow) s_nxt.holdHigh = s_r.cnt[15:8];
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_r        <= '0;
            s_r.cnt    <= timer_pkg::COUNT_RESET;
            s_r.ctl    <= timer_pkg::CONTROL_RESET;
            s_r.ch0Ctl <= timer_pkg::CHAN0_RESET;
        end else if (clkEn) begin
            s_r <= s_nxt;
        end
    end

    assign rdData        = s_r.rdData;
    assign tallyValue    = s_r.cnt;
    assign countingDown  = s_r.down;
    assign chan0Out      = s_r.outLvl;
    assign captureValue  = s_r.capVal;
    assign captureStrobe = s_r.capStb;
    assign chan0Trigger  = s_r.ch0Evt;
    // flags set regardless of masks; only the request is gated
    assign irqReq = timerIrqEnable && (
        (s_r.ctl[timer_pkg::CTL_CHAN0_BIT] && s_r.ch0Ctl[timer_pkg::CH0_MASK_BIT]) ||
        (s_r.ctl[timer_pkg::CTL_CHAN1_BIT] && chan1IrqMask) ||
        (s_r.ctl[timer_pkg::CTL_CHAN2_BIT] && chan2IrqMask) ||
        (s_r.ctl[timer_pkg::CTL_WRAP_BIT]  && wrapIrqMask));

    a_hold_latch: assert property (@(posedge clk) disable iff (!resetn)
        (clkEn && rdLow) |=> (s_r.holdHigh == $past(s_r.cnt[15:8])))
        else $error("high byte not held on low byte read");

    a_count_clear: assert property (@(posedge clk) disable iff (!resetn)
        (clkEn && wrLow) |=> (tallyValue == 16'h0000))
        else $error("counter not cleared by low byte write");

    a_suspend_hold: assert property (@(posedge clk) disable iff (!resetn)
        (mode == timer_pkg::MODE_HOLD && !wrLow) |=> $stable(tallyValue))
        else $error("counter moved while suspended");

    a_prescale_gate: assert property (@(posedge clk) disable iff (!resetn)
        (clkEn && !wrLow && !(tick && ((s_r.pre & preMask) == preMask)))
        |=> $stable(tallyValue))
        else $error("counter advanced off a prescaler edge");

    a_free_wrap: assert property (@(posedge clk) disable iff (!resetn)
        (clkEn && advance && !wrLow && mode == timer_pkg::MODE_FREE &&
         tallyValue == 16'hFFFF) |=> (tallyValue == 16'h0000 && s_r.ctl[4]))
        else $error("free-running wrap wrong");

    a_modulo_wrap: assert property (@(posedge clk) disable iff (!resetn)
        (clkEn && advance && !wrLow && mode == timer_pkg::MODE_MOD &&
         tallyValue == chan0MatchValue) |=> (tallyValue == 16'h0000))
        else $error("modulo restart wrong");

    a_updown_turn: assert property (@(posedge clk) disable iff (!resetn)
        (clkEn && advance && !wrLow && mode == timer_pkg::MODE_UPDN && !countingDown &&
         tallyValue == chan0MatchValue && tallyValue != 16'h0000)
        |=> (countingDown && tallyValue == $past(tallyValue) - 16'h0001))
        else $error("up/down turn at top wrong");

    a_zero_flags: assert property (@(posedge clk) disable iff (!resetn)
        (clkEn && wrapEvt && cmpMode && mode == timer_pkg::MODE_UPDN)
        |=> (s_r.ctl[5] && s_r.ctl[4] && chan0Trigger))
        else $error("zero turn did not set both flags");

    a_set_wins: assert property (@(posedge clk) disable iff (!resetn)
        (clkEn && wrCtl && chan1Event) |=> s_r.ctl[6])
        else $error("flag clear beat a hardware set");

    a_cmp_set: assert property (@(posedge clk) disable iff (!resetn)
        (clkEn && cmpMode && act == timer_pkg::ACT_SET && matchHit) |=> chan0Out)
        else $error("compare set action missed");

    a_irq_gate: assert property (@(posedge clk) disable iff (!resetn)
        irqReq |-> (timerIrqEnable && (|s_r.ctl[7:4])))
        else $error("request without enable or flag");

endmodule

`default_nettype wire

// ---- timer_core_bench.sv ----
// self-checking bench for the sixteen-bit timer core
// assumes the core's register port, tick and event inputs all run on clk
`timescale 1ns/100ps
`default_nettype none
module timer_core_bench;
    localparam logic [7:0] LO = timer_pkg::OFS_COUNT_LOW;
    localparam logic [7:0] HI = timer_pkg::OFS_COUNT_HIGH;
    localparam logic [7:0] CT = timer_pkg::OFS_CONTROL;
    localparam logic [7:0] C0 = timer_pkg::OFS_CHAN0_CTL;
    typedef struct packed {
        logic [7:0]  ctl;
        logic [15:0] match;
        logic [31:0] n;
        logic [15:0] cnt;
        logic [7:0]  ctlRd;
        logic        down;
    } row_t;
    logic                clk, resetn, clkEn, tick, capturePin, chan1Event, chan2Event;
    timer_pkg::bus_req_t busReq;
    logic [7:0]          rdData, radioEvent, radioEventMask;
    logic [15:0]         matchVal, tallyValue, captureValue;
    logic                chan1IrqMask, chan2IrqMask, wrapIrqMask, irqEnable, out;
    logic                countingDown, chan0Out, captureStrobe, chan0Trigger, irqReq;
    int                  failures, comparisons, totalTicks, t0;
    // compare actions in an order where each one must move the output
    int                  order[5] = '{0, 1, 3, 2, 4};
    // ctl, match, ticks, count, control readback, direction
    row_t rows[9] = '{
        '{8'h00, 16'h0000, 32'd5, 16'h0000, 8'h00, 1'b0},
        '{8'h01, 16'h0000, 32'd10, 16'h000A, 8'h01, 1'b0},
        '{8'h01, 16'h0000, 32'h300, 16'h0300, 8'h01, 1'b0},
        '{8'h01, 16'h0000, 32'h11234, 16'h1234, 8'h11, 1'b0},
        '{8'h02, 16'h0004, 32'd4, 16'h0004, 8'h02, 1'b0},
        '{8'h02, 16'h0004, 32'd5, 16'h0000, 8'h12, 1'b0},
        '{8'h03, 16'h0003, 32'd5, 16'h0001, 8'h03, 1'b1},
        '{8'h03, 16'h0003, 32'd6, 16'h0000, 8'h03, 1'b1},
        '{8'h03, 16'h0003, 32'd7, 16'h0001, 8'h13, 1'b0}};

    timer_core uut (
        .clk(clk), .resetn(resetn), .clkEn(clkEn), .busReq(busReq), .rdData(rdData),
        .tick(tick), .capturePin(capturePin), .radioEvent(radioEvent),
        .radioEventMask(radioEventMask), .chan0MatchValue(matchVal),
        .chan1Event(chan1Event), .chan2Event(chan2Event), .chan1IrqMask(chan1IrqMask),
        .chan2IrqMask(chan2IrqMask), .wrapIrqMask(wrapIrqMask),
        .timerIrqEnable(irqEnable), .tallyValue(tallyValue), .countingDown(countingDown),
        .chan0Out(chan0Out), .captureValue(captureValue), .captureStrobe(captureStrobe),
        .chan0Trigger(chan0Trigger), .irqReq(irqReq));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk) busReq <= '0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk) busReq <= '0;
        #1 check(name, {8'h00, rdData}, {8'h00, exp});
    endtask
    task automatic ticks(input int n);
        if (n > 0) begin
            @(posedge clk) tick <= 1'b1;
            repeat (n) @(posedge clk);
            tick <= 1'b0;
            totalTicks += n;
            #1;
        end
    endtask
    // stop, clear flags and count, then run with the new control value
    task automatic start(input logic [7:0] ctl, input logic [15:0] m);
        wr(CT, 8'h00);
        wr(LO, 8'h5A);
        matchVal <= m;
        wr(CT, ctl);
    endtask
    // prescaler counts every tick, so its phase is kept here
    function automatic int steps(input int first, input int n, input int mask);
        int s;
        s = 0;
        for (int k = first; k < first + n; k++) begin
            if ((k & mask) == mask) s++;
        end
        return s;
    endfunction
    task automatic watch(input logic exp);
        logic seen;
        seen = 1'b0;
        // looks at the current cycle first: a radio capture strobes at once
        repeat (8) begin
            #1;
            if (captureStrobe === 1'b1) begin
                seen = 1'b1;
                check("captured value", captureValue, 16'h0001);
            end
            @(posedge clk);
        end
        check("capture strobe", {15'h0, seen}, {15'h0, exp});
    endtask
    task automatic print_verdict();
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // the longest run is about 73k cycles
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        print_verdict();
    end

    initial begin
        {resetn, tick, capturePin, chan1Event, chan2Event, out} = '0;
        {chan1IrqMask, chan2IrqMask, wrapIrqMask, irqEnable} = '0;
        {busReq, radioEvent, matchVal, failures, comparisons, totalTicks} = '0;
        radioEventMask = 8'h04;
        clkEn = 1'b1;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        foreach (rows[i]) begin
            start(rows[i].ctl, rows[i].match);
            ticks(rows[i].n);
            rdchk("count low", LO, rows[i].cnt[7:0]);
            rdchk("count high", HI, rows[i].cnt[15:8]);
            rdchk("control", CT, rows[i].ctlRd);
            check("direction", {15'h0, countingDown}, {15'h0, rows[i].down});
        end
        // second reset with dirty state
        wr(C0, 8'h9C);
        @(posedge clk) resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        totalTicks = 0;
        rdchk("reset low", LO, 8'h00);
        wr(HI, 8'hFF);
        rdchk("reset high", HI, 8'h00);
        rdchk("reset control", CT, timer_pkg::CONTROL_RESET);
        rdchk("reset chan0", C0, timer_pkg::CHAN0_RESET);
        @(posedge clk) #1 check("read data released", {8'h00, rdData}, 16'h0000);
        rdchk("unmapped", 8'h10, 8'h00);
        start(8'h01, 16'h0000);
        ticks(16'h01FF);
        rdchk("latch low", LO, 8'hFF);
        ticks(1);
        check("count", tallyValue, 16'h0200);
        rdchk("held high", HI, 8'h01);
        wr(LO, 8'hA5);
        #1 check("cleared", tallyValue, 16'h0000);
        // ticks while disabled must neither count nor move the prescaler
        @(posedge clk) {clkEn, tick} <= 2'b01;
        repeat (3) @(posedge clk);
        {clkEn, tick} <= 2'b10;
        #1 check("frozen count", tallyValue, 16'h0000);
        for (int d = 0; d < 4; d++) begin
            t0 = totalTicks;
            start({4'h0, d[1:0], 2'b01}, 16'h0000);
            ticks(150);
            check("prescaled", tallyValue, 16'(steps(t0, 150, d ? (2 << 2 * d) - 1 : 0)));
        end
        foreach (order[i]) begin
            wr(C0, {2'b01, order[i][2:0], 3'b100});
            start(8'h02, 16'h0003);
            ticks(3);
            case (order[i])
                0, 3: out = 1'b1;
                1, 4: out = 1'b0;
                default: out = !out;
            endcase
            check("match output", {15'h0, chan0Out}, {15'h0, out});
            rdchk("match flag", CT, 8'h22);
            ticks(1);
            out = (order[i] == 3) ? 1'b0 : (order[i] == 4) ? 1'b1 : out;
            check("zero output", {15'h0, chan0Out}, {15'h0, out});
        end
        start(8'h03, 16'h0002);
        ticks(4);
        rdchk("before turn", CT, 8'h03);
        check("down at zero", {15'h0, countingDown}, 16'h0001);
        ticks(1);
        rdchk("turn flags", CT, 8'h33);
        wr(CT, 8'h00);
        wr(C0, 8'h00);
        @(posedge clk) chan2Event <= 1'b1;
        @(posedge clk) chan2Event <= 1'b0;
        rdchk("unmasked flag", CT, 8'h80);
        @(posedge clk) irqEnable <= 1'b1;
        #1 check("masked request", {15'h0, irqReq}, 16'h0000);
        @(posedge clk) chan2IrqMask <= 1'b1;
        #1 check("request", {15'h0, irqReq}, 16'h0001);
        @(posedge clk) irqEnable <= 1'b0;
        #1 check("disabled request", {15'h0, irqReq}, 16'h0000);
        @(posedge clk) begin
            busReq <= '{addr: CT, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
            chan1Event <= 1'b1;
        end
        @(posedge clk) begin
            busReq <= '0;
            chan1Event <= 1'b0;
        end
        rdchk("event wins", CT, 8'h40);
        wr(CT, 8'h10);
        rdchk("stored flag", CT, 8'h10);
        @(posedge clk) {wrapIrqMask, irqEnable} <= 2'b11;
        #1 check("wrap request", {15'h0, irqReq}, 16'h0001);
        wr(CT, 8'h00);
        #1 check("flag cleared", {15'h0, irqReq}, 16'h0000);
        for (int e = 0; e < 4; e++) begin
            wr(C0, {6'h00, e[1:0]});
            @(posedge clk) capturePin <= 1'b1;
            watch(e[0]);
            @(posedge clk) capturePin <= 1'b0;
            watch(e[1]);
        end
        rdchk("capture flag", CT, 8'h20);
        wr(C0, 8'h81);
        @(posedge clk) radioEvent <= 8'h02;
        @(posedge clk) radioEvent <= 8'h00;
        watch(1'b0);
        @(posedge clk) radioEvent <= 8'h04;
        @(posedge clk) radioEvent <= 8'h00;
        watch(1'b1);
        print_verdict();
    end
endmodule
`default_nettype wire
